// ---- rslk_pkg.sv ----
package rslk_pkg;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } rslk_bus_t;

endpackage : rslk_pkg

// ---- rslk_regs.svh ----
`ifndef RSLK_REGS_SVH
`define RSLK_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define RSLK_OFF_SECONDS   8'h00
`define RSLK_OFF_PRESCALE  8'h04
`define RSLK_OFF_ALARM     8'h08
`define RSLK_OFF_COMP      8'h0C
`define RSLK_OFF_CONTROL   8'h10
`define RSLK_OFF_STATUS    8'h14
`define RSLK_OFF_LOCK      8'h18
`define RSLK_OFF_IRQ_STS   8'h1C
`define RSLK_OFF_IRQ_MASK  8'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RSLK_ST_INVALID    0
`define RSLK_ST_OVERFLOW   1
`define RSLK_ST_ALARM      2
`define RSLK_ST_ENABLE     4
`define RSLK_LK_COMP       3
`define RSLK_LK_CONTROL    4
`define RSLK_LK_STATUS     5
`define RSLK_LK_LOCKREG    6
`define RSLK_CT_SWR        0
`define RSLK_CT_UPDATE     3
`define RSLK_IRQ_TICK      0
`define RSLK_IRQ_OVERFLOW  1
`define RSLK_IRQ_ALARM     2

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define RSLK_LOCK_RST      4'hF
`define RSLK_LOCK_FIXED_HI 1'b1
`define RSLK_LOCK_FIXED_LO 3'h7
`define RSLK_SEC_MAX       32'hFFFFFFFF
`define RSLK_PRE_ROLL      15'h7FFF
`define RSLK_CLK_HZ        250000000
`define RSLK_TICK_HZ       32768
`define RSLK_TICK_CYCLES   (`RSLK_CLK_HZ / `RSLK_TICK_HZ)

`endif

// ---- rslk_tick_div.sv ----
`timescale 1ns/100ps

module rslk_tick_div #(
  parameter int DIV = 7629
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);

  logic [15:0] cnt_reg;
  wire         at_end = (cnt_reg == 16'(DIV - 1));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_reg <= 16'h0000;
    else
      cnt_reg <= at_end ? 16'h0000 : cnt_reg + 16'h0001;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tick <= 1'b0;
    else
      tick <= at_end;
  end

endmodule : rslk_tick_div

// ---- rslk_top.sv ----
`timescale 1ns/100ps
`include "rslk_regs.svh"

// Summary of operation
// - With the enable bit clear the seconds and prescaler counters take writes and stand still, with it set they ignore writes and count unless frozen.
// - The alarm flag sets when the alarm value equals the seconds count as the seconds count increments.
// - Any write to the alarm value clears the alarm flag unless an alarm match sets it in the same cycle.
// - The overflow flag sets when the enabled seconds count overflows.
// - While overflow or invalid is set both counters stop and read as zero.
// - Writing the seconds count while disabled clears overflow and invalid.
// - Power-on and soft reset set the invalid flag.
// - Status bits 31 to 5 and 3 and lock bits 31 to 8 read zero.
// - Lock bit 7 and the lowest reserved lock field read one.
// - A locked lock-register lock blocks all lock writes until a reset sets it again.
// - A locked status lock blocks status writes until a reset sets it again.
// - A locked control lock blocks control writes and only power-on reset sets it again.
// - A locked compensation lock blocks compensation writes until a reset sets it again.
// - With update mode set the enable bit stays writable under status lock when overflow or invalid is set or enable is clear.
// - Writing the soft reset bit as one resets every register but that bit and the control lock; software clears the bit.
module rslk_top #(
  parameter int TICK_DIV = `RSLK_TICK_CYCLES
) (
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             RTC_IRQ
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  rslk_pkg::rslk_bus_t bus_reg;
  logic [31:0] seconds_reg;
  logic [15:0] prescale_reg;
  logic [31:0] alarm_reg;
  logic [31:0] comp_reg;
  logic        swr_reg;
  logic        update_mode_reg;
  logic        enable_reg;
  logic        alarm_flag_reg;
  logic        overflow_flag_reg;
  logic        invalid_flag_reg;
  logic [3:0]  lock_reg;
  logic [2:0]  irq_sts_reg;
  logic [2:0]  irq_mask_reg;
  logic [31:0] rdata_reg;
  logic        tick;

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  wire        req      = WB_CYC_I & WB_STB_I;
  wire        wr_go    = WB_ACK_O & req & WB_WE_I;
  wire        rd_go    = WB_ACK_O & req & ~WB_WE_I;
  wire        hit_sec  = (WB_ADR_I == `RSLK_OFF_SECONDS);
  wire        hit_pre  = (WB_ADR_I == `RSLK_OFF_PRESCALE);
  wire        hit_alm  = (WB_ADR_I == `RSLK_OFF_ALARM);
  wire        hit_comp = (WB_ADR_I == `RSLK_OFF_COMP);
  wire        hit_ctl  = (WB_ADR_I == `RSLK_OFF_CONTROL);
  wire        hit_st   = (WB_ADR_I == `RSLK_OFF_STATUS);
  wire        hit_lk   = (WB_ADR_I == `RSLK_OFF_LOCK);
  wire        hit_ists = (WB_ADR_I == `RSLK_OFF_IRQ_STS);
  wire        hit_imsk = (WB_ADR_I == `RSLK_OFF_IRQ_MASK);
  wire [31:0] wmask    = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                          {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  wire        wr_b0    = wr_go & WB_SEL_I[0];

  // Soft reset is a level: it holds the block in defaults while set
  wire        srst     = swr_reg;

  // --------------------------------------------------------------------
  // Lock gating
  // --------------------------------------------------------------------
  wire        lk_comp  = lock_reg[`RSLK_LK_COMP - 3];
  wire        lk_ctl   = lock_reg[`RSLK_LK_CONTROL - 3];
  wire        lk_st    = lock_reg[`RSLK_LK_STATUS - 3];
  wire        lk_lk    = lock_reg[`RSLK_LK_LOCKREG - 3];
  wire        frozen   = overflow_flag_reg | invalid_flag_reg;
  wire        run      = enable_reg & ~frozen;
  wire        wr_lock  = wr_b0 & hit_lk & lk_lk;
  wire        wr_ctl   = wr_b0 & hit_ctl & lk_ctl;
  wire        wr_comp  = wr_go & hit_comp & lk_comp;
  wire        wr_en    = wr_b0 & hit_st &
                         (lk_st | (update_mode_reg & (frozen | ~enable_reg)));
  wire        wr_sec   = wr_go & hit_sec & ~enable_reg;
  wire        wr_pre   = wr_go & hit_pre & ~enable_reg;
  wire        wr_alm   = wr_go & hit_alm;

  // --------------------------------------------------------------------
  // Counting events
  // --------------------------------------------------------------------
  // Seconds step on the falling edge of prescaler bit 14
  wire        pre_inc   = run & tick;
  wire        sec_inc   = pre_inc & (prescale_reg[14:0] == `RSLK_PRE_ROLL);
  wire        alarm_set = sec_inc & (alarm_reg == seconds_reg);
  wire        ovf_set   = sec_inc & (seconds_reg == `RSLK_SEC_MAX);
  wire [2:0]  irq_ev    = {alarm_set, ovf_set, sec_inc};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                        input logic [31:0] d);
    merge = (old & ~m) | (d & m);
  endfunction : merge

  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------
  // fixed read bits
  wire [31:0] st_rd  = {27'h0, enable_reg, 1'b0, alarm_flag_reg,
                        overflow_flag_reg, invalid_flag_reg};
  wire [31:0] lk_rd  = {24'h0, `RSLK_LOCK_FIXED_HI, lock_reg, `RSLK_LOCK_FIXED_LO};
  wire [31:0] ctl_rd = {28'h0, update_mode_reg, 2'b00, swr_reg};
  wire [31:0] sec_rd = frozen ? 32'h0 : seconds_reg;
  wire [31:0] pre_rd = frozen ? 32'h0 : {16'h0, prescale_reg};
  wire [31:0] rd_mux = hit_sec  ? sec_rd :
                       hit_pre  ? pre_rd :
                       hit_alm  ? alarm_reg :
                       hit_comp ? comp_reg :
                       hit_ctl  ? ctl_rd :
                       hit_st   ? st_rd :
                       hit_lk   ? lk_rd :
                       hit_ists ? {29'h0, irq_sts_reg} :
                       hit_imsk ? {29'h0, irq_mask_reg} : 32'h0;

  // --------------------------------------------------------------------
  // Time base
  // --------------------------------------------------------------------
  rslk_tick_div #(
    .DIV (TICK_DIV)
  ) u_tick (
    .clk  (CORE_CLK),
    .rst  (SYS_RST),
    .tick (tick)
  );

  // --------------------------------------------------------------------
  // Wishbone slave: answer one cycle after the request, any address
  // --------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      bus_reg <= rslk_pkg::BUS_IDLE;
    else
      unique case (bus_reg)
        rslk_pkg::BUS_IDLE: bus_reg <= req ? rslk_pkg::BUS_ACK : rslk_pkg::BUS_IDLE;
        rslk_pkg::BUS_ACK:  bus_reg <= rslk_pkg::BUS_IDLE;
      endcase
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      rdata_reg <= 32'h0;
    else if (req & ~WB_ACK_O)
      rdata_reg <= rd_mux;
  end

  assign WB_ACK_O = (bus_reg == rslk_pkg::BUS_ACK);
  assign WB_DAT_O = rdata_reg;

  // --------------------------------------------------------------------
  // Counters, alarm value and compensation value
  // --------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST | srst)
    begin
      seconds_reg  <= 32'h0;
      prescale_reg <= 16'h0;
      alarm_reg    <= 32'h0;
      comp_reg     <= 32'h0;
    end
    else
    begin
      // write while disabled, count while running
      if (wr_sec)
        seconds_reg <= merge(seconds_reg, wmask, WB_DAT_I);
      else if (sec_inc)
        seconds_reg <= seconds_reg + 32'h1;
      if (wr_pre)
        prescale_reg <= 16'(merge({16'h0, prescale_reg}, wmask, WB_DAT_I));
      else if (pre_inc)
        prescale_reg <= prescale_reg + 16'h1;
      if (wr_alm)
        alarm_reg <= merge(alarm_reg, wmask, WB_DAT_I);
      if (wr_comp)
        comp_reg <= merge(comp_reg, wmask, WB_DAT_I);
    end
  end

  // --------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST | srst)
    begin
      enable_reg        <= 1'b0;
      alarm_flag_reg    <= 1'b0;
      overflow_flag_reg <= 1'b0;
      invalid_flag_reg  <= 1'b1;
    end
    else
    begin
      if (wr_en)
        enable_reg <= WB_DAT_I[`RSLK_ST_ENABLE];
      alarm_flag_reg    <= alarm_set | (alarm_flag_reg & ~wr_alm);
      overflow_flag_reg <= ovf_set | (overflow_flag_reg & ~wr_sec);
      invalid_flag_reg  <= invalid_flag_reg & ~wr_sec;
    end
  end

  // --------------------------------------------------------------------
  // Locks and control
  // --------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      lock_reg <= `RSLK_LOCK_RST;
    else if (srst)
      // soft reset leaves the control lock alone
      lock_reg <= `RSLK_LOCK_RST & {2'h3, lk_ctl, 1'h1};
    else if (wr_lock)
      lock_reg <= lock_reg & WB_DAT_I[6:3];
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      swr_reg         <= 1'b0;
      update_mode_reg <= 1'b0;
    end
    else
    begin
      // soft reset bit survives its own reset
      if (wr_ctl)
        swr_reg <= WB_DAT_I[`RSLK_CT_SWR];
      if (srst)
        update_mode_reg <= 1'b0;
      else if (wr_ctl)
        update_mode_reg <= WB_DAT_I[`RSLK_CT_UPDATE];
    end
  end

  // --------------------------------------------------------------------
  // Interrupts: sticky events, cleared by reading, set wins
  // --------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST | srst)
    begin
      irq_sts_reg  <= 3'h0;
      irq_mask_reg <= 3'h0;
    end
    else
    begin
      irq_sts_reg <= irq_ev | (irq_sts_reg & ~{3{rd_go & hit_ists}});
      if (wr_b0 & hit_imsk)
        irq_mask_reg <= WB_DAT_I[2:0];
    end
  end

  assign RTC_IRQ = |(irq_sts_reg & irq_mask_reg);

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_sec_write_running;
    wr_go & hit_sec & enable_reg & ~sec_inc;
  endsequence

  sequence s_lock_write_blocked;
    wr_go & hit_lk & ~lk_lk & ~srst;
  endsequence

  chk_enable_blocks_write: assert property (
    s_sec_write_running |=> $stable(seconds_reg))
    else $error("seconds changed on a write while enabled");
  chk_alarm_flag_set: assert property (
    (alarm_set & ~srst) |=> alarm_flag_reg)
    else $error("alarm flag missed a match");
  chk_alarm_flag_clear: assert property (
    (wr_alm & ~alarm_set) |=> ~alarm_flag_reg)
    else $error("alarm flag survived an alarm write");
  chk_overflow_set: assert property (
    (sec_inc & seconds_reg == `RSLK_SEC_MAX & ~srst) |=> overflow_flag_reg ##1 $stable(seconds_reg))
    else $error("overflow not flagged or counter moved");
  chk_frozen_counters: assert property (
    (frozen & ~wr_sec & ~wr_pre & ~srst) |=> $stable(seconds_reg) && $stable(prescale_reg))
    else $error("frozen counter moved");
  chk_frozen_read_zero: assert property (
    (req & ~WB_ACK_O & ~WB_WE_I & (hit_sec | hit_pre) & frozen) |=> (WB_DAT_O == 32'h0))
    else $error("frozen counter read nonzero");
  chk_flags_clear: assert property (
    (wr_sec & ~ovf_set & ~srst) |=> ~overflow_flag_reg & ~invalid_flag_reg)
    else $error("seconds write left a flag set");
  chk_soft_invalid: assert property (
    srst |=> invalid_flag_reg & ~enable_reg)
    else $error("soft reset did not mark time invalid");
  chk_status_zero: assert property (
    (req & ~WB_ACK_O & hit_st & ~WB_WE_I) |=> (WB_DAT_O[31:5] == 27'h0) && !WB_DAT_O[3])
    else $error("reserved status bits read nonzero");
  chk_lock_ones: assert property (
    (req & ~WB_ACK_O & hit_lk & ~WB_WE_I) |=> (WB_DAT_O[31:7] == 25'h1) && (WB_DAT_O[2:0] == 3'h7))
    else $error("fixed lock bits read wrong");
  chk_lock_frozen: assert property (
    s_lock_write_blocked |=> $stable(lock_reg))
    else $error("lock register changed while locked");
  chk_lock_one_way: assert property (
    (~srst & ~$past(srst)) |-> ((lock_reg & ~$past(lock_reg)) == 4'h0))
    else $error("lock bit returned to unlocked without reset");

endmodule : rslk_top

// ---- rtc_status_and_lock_logic_bench.sv ----
`timescale 1ns/100ps
`include "rslk_regs.svh"

module rtc_status_and_lock_logic_bench;
  // Short tick divider keeps a counter step within a few dozen cycles
  localparam int TDIV = 4;

  logic        core_clk   = 1'b0;
  logic        sys_rst    = 1'b1;
  logic        cyc        = 1'b0;
  logic        stb        = 1'b0;
  logic        we         = 1'b0;
  logic [7:0]  adr        = 8'h00;
  logic [3:0]  sel        = 4'hF;
  logic [31:0] wdat       = 32'h0;
  logic [31:0] dat_o;
  logic        ack;
  logic        irq;
  logic [31:0] v;
  int          bad_count  = 0;
  int          num_checks = 0;

  always #2 core_clk = ~core_clk;

  rslk_top #(
    .TICK_DIV (TDIV)
  ) dut (
    .CORE_CLK (core_clk),
    .SYS_RST  (sys_rst),
    .WB_CYC_I (cyc),
    .WB_STB_I (stb),
    .WB_WE_I  (we),
    .WB_ADR_I (adr),
    .WB_SEL_I (sel),
    .WB_DAT_I (wdat),
    .WB_DAT_O (dat_o),
    .WB_ACK_O (ack),
    .RTC_IRQ  (irq)
  );

  // ----------------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic stop_test;
    if (bad_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t value mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Holds the request until ack is sampled, then leaves one idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    // No cycle count is assumed here; a missing answer is caught by the watchdog
    do
      @(posedge core_clk);
    while (ack !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, a, d, t);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] t;
    bus(1'b0, a, 32'h0, t);
    chk(t, exp);
  endtask : rc

  task automatic por;
    sys_rst <= 1'b1;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
  endtask : por

  // ----------------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    $display("[ERR] %0t run did not finish", $time);
    stop_test();
  end

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial
  begin
    por();
    rc(`RSLK_OFF_STATUS, 32'h00000001);
    rc(`RSLK_OFF_LOCK, 32'h000000FF);
    rc(`RSLK_OFF_SECONDS, 32'h00000000);
    wr(8'h40, 32'hFFFFFFFF);
    rc(8'h40, 32'h00000000);
    // A seconds write while enabled is ignored and leaves the invalid flag set
    wr(`RSLK_OFF_STATUS, 32'hFFFFFFFF);
    rc(`RSLK_OFF_STATUS, 32'h00000011);
    wr(`RSLK_OFF_SECONDS, 32'h00000007);
    rc(`RSLK_OFF_STATUS, 32'h00000011);
    wr(`RSLK_OFF_STATUS, 32'h00000000);
    // Alarm on the step out of the alarm second
    wr(`RSLK_OFF_PRESCALE, 32'h00007FFE);
    wr(`RSLK_OFF_SECONDS, 32'h00000005);
    rc(`RSLK_OFF_STATUS, 32'h00000000);
    wr(`RSLK_OFF_ALARM, 32'h00000005);
    wr(`RSLK_OFF_IRQ_MASK, 32'h00000004);
    rc(`RSLK_OFF_IRQ_MASK, 32'h00000004);
    repeat (40) @(posedge core_clk);
    rc(`RSLK_OFF_SECONDS, 32'h00000005);
    chk({31'h0, irq}, 32'h0);
    wr(`RSLK_OFF_STATUS, 32'h00000010);
    repeat (40) @(posedge core_clk);
    rc(`RSLK_OFF_STATUS, 32'h00000014);
    rc(`RSLK_OFF_SECONDS, 32'h00000006);
    chk({31'h0, irq}, 32'h1);
    wr(`RSLK_OFF_SECONDS, 32'h00000009);
    rc(`RSLK_OFF_SECONDS, 32'h00000006);
    rc(`RSLK_OFF_IRQ_STS, 32'h00000005);
    chk({31'h0, irq}, 32'h0);
    rc(`RSLK_OFF_IRQ_STS, 32'h00000000);
    wr(`RSLK_OFF_ALARM, 32'h00000000);
    rc(`RSLK_OFF_STATUS, 32'h00000010);
    // Overflow freezes both counters and reads them as zero
    wr(`RSLK_OFF_STATUS, 32'h00000000);
    wr(`RSLK_OFF_PRESCALE, 32'h00007FFE);
    wr(`RSLK_OFF_SECONDS, 32'hFFFFFFFF);
    wr(`RSLK_OFF_IRQ_MASK, 32'h00000002);
    wr(`RSLK_OFF_STATUS, 32'h00000010);
    repeat (40) @(posedge core_clk);
    rc(`RSLK_OFF_STATUS, 32'h00000012);
    rc(`RSLK_OFF_SECONDS, 32'h00000000);
    rc(`RSLK_OFF_PRESCALE, 32'h00000000);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, `RSLK_OFF_IRQ_STS, 32'h0, v);
    chk(v & 32'h00000002, 32'h00000002);
    wr(`RSLK_OFF_STATUS, 32'h00000000);
    wr(`RSLK_OFF_SECONDS, 32'h00000003);
    rc(`RSLK_OFF_STATUS, 32'h00000000);
    rc(`RSLK_OFF_SECONDS, 32'h00000003);
    // Compensation and status locks, update mode escape
    wr(`RSLK_OFF_COMP, 32'h000000AA);
    wr(`RSLK_OFF_LOCK, 32'hFFFFFFD7);
    rc(`RSLK_OFF_LOCK, 32'h000000D7);
    wr(`RSLK_OFF_COMP, 32'h00000055);
    rc(`RSLK_OFF_COMP, 32'h000000AA);
    wr(`RSLK_OFF_STATUS, 32'h00000010);
    rc(`RSLK_OFF_STATUS, 32'h00000000);
    wr(`RSLK_OFF_CONTROL, 32'h00000008);
    wr(`RSLK_OFF_STATUS, 32'h00000010);
    rc(`RSLK_OFF_STATUS, 32'h00000010);
    wr(`RSLK_OFF_STATUS, 32'h00000000);
    rc(`RSLK_OFF_STATUS, 32'h00000010);
    // Soft reset restores defaults but leaves its own bit set
    wr(`RSLK_OFF_CONTROL, 32'h00000009);
    rc(`RSLK_OFF_STATUS, 32'h00000001);
    rc(`RSLK_OFF_LOCK, 32'h000000FF);
    rc(`RSLK_OFF_COMP, 32'h00000000);
    rc(`RSLK_OFF_CONTROL, 32'h00000001);
    wr(`RSLK_OFF_CONTROL, 32'h00000000);
    rc(`RSLK_OFF_CONTROL, 32'h00000000);
    // Control lock blocks the soft reset write; lock register lock
    wr(`RSLK_OFF_LOCK, 32'h000000EF);
    wr(`RSLK_OFF_CONTROL, 32'h00000009);
    rc(`RSLK_OFF_CONTROL, 32'h00000000);
    wr(`RSLK_OFF_LOCK, 32'h000000BF);
    rc(`RSLK_OFF_LOCK, 32'h000000AF);
    wr(`RSLK_OFF_LOCK, 32'h000000F7);
    rc(`RSLK_OFF_LOCK, 32'h000000AF);
    wr(`RSLK_OFF_LOCK, 32'hFFFFFFFF);
    rc(`RSLK_OFF_LOCK, 32'h000000AF);
    por();
    rc(`RSLK_OFF_LOCK, 32'h000000FF);
    rc(`RSLK_OFF_STATUS, 32'h00000001);
    wr(`RSLK_OFF_CONTROL, 32'h00000008);
    rc(`RSLK_OFF_CONTROL, 32'h00000008);
    stop_test();
  end
endmodule : rtc_status_and_lock_logic_bench
